// ==== hdl/opdec_pkg.sv ====
// Package with the constants, enumerations and carriers shared by the opcode decoder.
package opdec_pkg;

  // ==========================================================================
  // Register file addresses and status bit positions
  // ==========================================================================
  localparam logic [7:0] STATUS_ADDR = 8'hD5;
  localparam int FAST_IRQ_BIT = 1;
  localparam int BANK_BIT = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ==========================================================================
  // Operand range limits
  // ==========================================================================
  localparam logic [3:0] WORK_REG_MAX = 4'hF;
  localparam logic [3:0] PAIR_IDX_MAX = 4'hE;
  localparam logic [7:0] PAIR_REG_MAX = 8'hFE;
  localparam logic [3:0] WORK_SHORT_TAG = 4'hC;

  // ==========================================================================
  // Opcode nibble values used by the decoder
  // ==========================================================================
  localparam logic [3:0] NIB_0 = 4'h0;
  localparam logic [3:0] NIB_1 = 4'h1;
  localparam logic [3:0] NIB_2 = 4'h2;
  localparam logic [3:0] NIB_3 = 4'h3;
  localparam logic [3:0] NIB_4 = 4'h4;
  localparam logic [3:0] NIB_5 = 4'h5;
  localparam logic [3:0] NIB_6 = 4'h6;
  localparam logic [3:0] NIB_7 = 4'h7;
  localparam logic [3:0] NIB_8 = 4'h8;
  localparam logic [3:0] NIB_9 = 4'h9;
  localparam logic [3:0] NIB_A = 4'hA;
  localparam logic [3:0] NIB_B = 4'hB;
  localparam logic [3:0] NIB_C = 4'hC;
  localparam logic [3:0] NIB_D = 4'hD;
  localparam logic [3:0] NIB_E = 4'hE;
  localparam logic [3:0] NIB_F = 4'hF;
  localparam logic [7:0] OPC_SEL_BANK0 = 8'h4F;
  localparam logic [7:0] OPC_SEL_BANK1 = 8'h5F;
  localparam logic [7:0] OPC_IRQ_RETURN = 8'hBF;

  // ==========================================================================
  // Operations
  // ==========================================================================
  typedef enum logic [5:0] {
    OP_INVALID, OP_ADD, OP_ADC, OP_SUB, OP_SUB_BORROW, OP_OR, OP_AND, OP_TEST_INV_MASK,
    OP_TEST_MASK, OP_COMPARE, OP_XOR, OP_DECREMENT, OP_ROT_LEFT_CARRY, OP_INC,
    OP_DECIMAL_ADJUST, OP_POP, OP_COM, OP_PUSH, OP_ROT_LEFT, OP_CLEAR, OP_ROT_RIGHT_CARRY,
    OP_ARITH_SHIFT_RIGHT, OP_ROT_RIGHT, OP_SWAP, OP_MULTIPLY, OP_DIV, OP_WORD_DECREMENT,
    OP_WORD_INCREMENT, OP_WORD_LOAD, OP_PUSH_UD, OP_PUSH_UI, OP_POP_UD, OP_POP_UI, OP_BIT_OR,
    OP_BIT_CMP, OP_BIT_XOR, OP_BIT_BRANCH, OP_BIT_LOAD, OP_BIT_INV, OP_BIT_AND,
    OP_BIT_SETRST, OP_PM_LOAD, OP_PM_LOAD_DEC, OP_PM_LOAD_INC, OP_PM_STORE_PD,
    OP_PM_STORE_PI, OP_JUMP, OP_SET_RP, OP_CALL, OP_CMP_INC_EQ, OP_CMP_INC_NE,
    OP_LOAD, OP_UPPER_HALF
  } operation_t;

  // Operand forms presented beside the operation.
  typedef enum logic [3:0] {
    MODE_NONE, MODE_WREG_WREG, MODE_WREG_IWREG, MODE_REG_REG, MODE_IREG_REG,
    MODE_REG_IMM, MODE_REG, MODE_IREG, MODE_PAIR, MODE_BIT, MODE_IND_PAIR,
    MODE_SHORT_INDEX, MODE_LONG_INDEX, MODE_TABLE_IND, MODE_PC_REL, MODE_DIRECT
  } mode_t;

  // Decode result carried as one bundle.
  typedef struct packed {
    logic valid;
    operation_t op;
    mode_t mode;
    logic [1:0] operand_bytes;
    logic invalid;
    logic fast_return;
  } decode_t;

  // Decoder state.
  typedef enum logic [1:0] {
    ST_FETCH = 2'b01,
    ST_OPERANDS = 2'b10
  } state_t;

endpackage

// ==== hdl/opcode_decoder.sv ====
// Opcode decoder for the low lower-nibble half of the opcode map with the status register bits.
`timescale 1ns/100ps

module opcode_decoder
  import opdec_pkg::*;
#(
  parameter int ADDR_WIDTH = 16
)
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic opcode_valid_in,
  input wire logic [7:0] opcode_in,
  input wire logic operand_valid_in,
  input wire logic [7:0] operand_in,
  input wire logic [ADDR_WIDTH-1:0] next_pc_in,
  input wire logic fast_irq_begin_in,
  input wire logic flags_update_in,
  input wire logic [5:0] flags_result_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  output opdec_pkg::decode_t decode_out,
  output logic opcode_ready_out,
  output logic irq_block_out,
  output logic bank_select_out,
  output logic [7:0] operand_reg_out,
  output logic [2:0] operand_bit_out,
  output logic [ADDR_WIDTH-1:0] target_out,
  output logic target_valid_out
);
  import opdec_pkg::*;

  // The target arithmetic is written for a 16-bit program address only.
  if (ADDR_WIDTH != 16)
  begin : g_width_check
    $error("opcode_decoder supports a 16-bit address only");
  end

  // ==========================================================================
  // Decode table
  // ==========================================================================
  // Pure table lookup so the answer stands in the acceptance cycle.
  function automatic decode_t decode_byte(input logic [7:0] opc, input logic fast_flag);
    decode_t d;
    logic [3:0] hi;
    logic [3:0] lo;
    d = '0;
    hi = opc[7:4];
    lo = opc[3:0];
    d.valid = 1'b1;
    d.op = OP_UPPER_HALF;
    d.mode = MODE_NONE;
    d.operand_bytes = 2'd1;
    if (lo <= NIB_7)
    begin
      if (lo >= NIB_2 && lo <= NIB_6 && (hi <= NIB_7 || hi == NIB_A || hi == NIB_B))
      begin
        case (hi)
          NIB_0: d.op = OP_ADD;
          NIB_1: d.op = OP_ADC;
          NIB_2: d.op = OP_SUB;
          NIB_3: d.op = OP_SUB_BORROW;
          NIB_4: d.op = OP_OR;
          NIB_5: d.op = OP_AND;
          NIB_6: d.op = OP_TEST_INV_MASK;
          NIB_7: d.op = OP_TEST_MASK;
          NIB_A: d.op = OP_COMPARE;
          default: d.op = OP_XOR;
        endcase
        case (lo)
          NIB_2: d.mode = MODE_WREG_WREG;
          NIB_3: d.mode = MODE_WREG_IWREG;
          NIB_4: d.mode = MODE_REG_REG;
          NIB_5: d.mode = MODE_IREG_REG;
          default: d.mode = MODE_REG_IMM;
        endcase
        d.operand_bytes = (lo <= NIB_3) ? 2'd1 : 2'd2;
      end
      else if (lo <= NIB_1)
      begin
        d.mode = (lo == NIB_0) ? MODE_REG : MODE_IREG;
        case (hi)
          NIB_0: d.op = OP_DECREMENT;
          NIB_1: d.op = OP_ROT_LEFT_CARRY;
          NIB_2: d.op = OP_INC;
          NIB_3:
          begin
            d.op = (lo == NIB_0) ? OP_JUMP : OP_SET_RP;
            d.mode = (lo == NIB_0) ? MODE_IND_PAIR : MODE_REG_IMM;
          end
          NIB_4: d.op = OP_DECIMAL_ADJUST;
          NIB_5: d.op = OP_POP;
          NIB_6: d.op = OP_COM;
          NIB_7: d.op = OP_PUSH;
          NIB_8: d.op = OP_WORD_DECREMENT;
          NIB_9: d.op = OP_ROT_LEFT;
          NIB_A: d.op = OP_WORD_INCREMENT;
          NIB_B: d.op = OP_CLEAR;
          NIB_C: d.op = OP_ROT_RIGHT_CARRY;
          NIB_D: d.op = OP_ARITH_SHIFT_RIGHT;
          NIB_E: d.op = OP_ROT_RIGHT;
          default: d.op = OP_SWAP;
        endcase
        if ((hi == NIB_8 || hi == NIB_A) && lo == NIB_0)
          d.mode = MODE_PAIR;
      end
      else if (lo == NIB_7)
      begin
        d.mode = MODE_BIT;
        d.operand_bytes = 2'd2;
        case (hi)
          NIB_0: d.op = OP_BIT_OR;
          NIB_1: d.op = OP_BIT_CMP;
          NIB_2: d.op = OP_BIT_XOR;
          NIB_3: d.op = OP_BIT_BRANCH;
          NIB_4: d.op = OP_BIT_LOAD;
          NIB_5:
          begin
            d.op = OP_BIT_INV;
            d.operand_bytes = 2'd1;
          end
          NIB_6: d.op = OP_BIT_AND;
          NIB_7:
          begin
            d.op = OP_BIT_SETRST;
            d.operand_bytes = 2'd1;
          end
          NIB_A, NIB_B:
          begin
            d.op = OP_PM_LOAD;
            d.mode = MODE_LONG_INDEX;
            d.operand_bytes = 2'd3;
          end
          NIB_E, NIB_F:
          begin
            d.op = OP_PM_LOAD;
            d.mode = MODE_SHORT_INDEX;
          end
          default:
          begin
            d.op = OP_LOAD;
            d.mode = MODE_WREG_IWREG;
            d.operand_bytes = (hi <= NIB_9) ? 2'd2 : 2'd1;
          end
        endcase
      end
      else
      begin
        // Rows 8, 9, C to F in columns 2 to 6.
        d.mode = MODE_REG_REG;
        d.operand_bytes = 2'd2;
        case ({hi, lo})
          {NIB_8, NIB_2}: d.op = OP_PUSH_UD;
          {NIB_8, NIB_3}: d.op = OP_PUSH_UI;
          {NIB_9, NIB_2}: d.op = OP_POP_UD;
          {NIB_9, NIB_3}: d.op = OP_POP_UI;
          {NIB_8, NIB_4}, {NIB_8, NIB_5}, {NIB_8, NIB_6}: d.op = OP_MULTIPLY;
          {NIB_9, NIB_4}, {NIB_9, NIB_5}, {NIB_9, NIB_6}: d.op = OP_DIV;
          {NIB_C, NIB_2}:
          begin
            d.op = OP_CMP_INC_EQ;
            d.mode = MODE_PC_REL;
          end
          {NIB_D, NIB_2}:
          begin
            d.op = OP_CMP_INC_NE;
            d.mode = MODE_PC_REL;
          end
          {NIB_C, NIB_3}, {NIB_D, NIB_3}:
          begin
            d.op = OP_PM_LOAD;
            d.mode = MODE_IND_PAIR;
            d.operand_bytes = 2'd1;
          end
          {NIB_E, NIB_2}: d.op = OP_PM_LOAD_DEC;
          {NIB_E, NIB_3}: d.op = OP_PM_LOAD_INC;
          {NIB_F, NIB_2}: d.op = OP_PM_STORE_PD;
          {NIB_F, NIB_3}: d.op = OP_PM_STORE_PI;
          {NIB_C, NIB_4}, {NIB_C, NIB_5}: d.op = OP_WORD_LOAD;
          {NIB_C, NIB_6}:
          begin
            d.op = OP_WORD_LOAD;
            d.mode = MODE_REG_IMM;
            d.operand_bytes = 2'd3;
          end
          {NIB_D, NIB_4}:
          begin
            d.op = OP_CALL;
            d.mode = MODE_TABLE_IND;
            d.operand_bytes = 2'd1;
          end
          {NIB_F, NIB_4}:
          begin
            d.op = OP_CALL;
            d.mode = MODE_IND_PAIR;
            d.operand_bytes = 2'd1;
          end
          {NIB_F, NIB_6}:
          begin
            d.op = OP_CALL;
            d.mode = MODE_DIRECT;
          end
          {NIB_D, NIB_5}:
          begin
            d.op = OP_INVALID;
            d.mode = MODE_NONE;
            d.operand_bytes = 2'd0;
            d.invalid = 1'b1;
          end
          {NIB_D, NIB_6}, {NIB_E, NIB_6}:
          begin
            d.op = OP_LOAD;
            d.mode = MODE_REG_IMM;
          end
          default: d.op = OP_LOAD;
        endcase
        if (hi == NIB_E || hi == NIB_F)
          if (lo == NIB_2 || lo == NIB_3)
          begin
            d.mode = MODE_IND_PAIR;
            d.operand_bytes = 2'd1;
          end
      end
    end
    else if (opc == OPC_IRQ_RETURN || opc == OPC_SEL_BANK0 || opc == OPC_SEL_BANK1)
      d.operand_bytes = 2'd0;
    d.fast_return = (opc == OPC_IRQ_RETURN) && fast_flag;
    return d;
  endfunction

  // ==========================================================================
  // Sequencing
  // ==========================================================================
  state_t state_reg;
  logic [1:0] remaining_reg;
  decode_t current_reg;
  logic [7:0] first_operand_reg;
  decode_t comb_decode;
  logic [7:0] status_reg;
  logic accept;

  assign comb_decode = decode_byte(opcode_in, status_reg[FAST_IRQ_BIT]);
  assign opcode_ready_out = (state_reg == ST_FETCH);
  assign accept = opcode_valid_in && opcode_ready_out;

  // Combinational presentation in the acceptance cycle avoids a bubble per opcode.
  always_comb
  begin
    decode_out = current_reg;
    if (accept)
      decode_out = comb_decode;
  end

  // Waits for the announced operand bytes before the next opcode is taken.
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      state_reg <= ST_FETCH;
      remaining_reg <= 2'd0;
      current_reg <= '0;
    end
    else
    begin
      case (state_reg)
        ST_FETCH:
          if (accept)
          begin
            current_reg <= comb_decode;
            remaining_reg <= comb_decode.operand_bytes;
            if (comb_decode.operand_bytes != 2'd0)
              state_reg <= ST_OPERANDS;
          end
        ST_OPERANDS:
          if (operand_valid_in)
          begin
            remaining_reg <= remaining_reg - 2'd1;
            if (remaining_reg == 2'd1)
              state_reg <= ST_FETCH;
          end
        default: state_reg <= ST_FETCH;
      endcase
    end
  end

  // ==========================================================================
  // Operand fields
  // ==========================================================================
  // Last operand byte kept so the next byte can form a pair or displacement.
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      first_operand_reg <= 8'h00;
      operand_reg_out <= 8'h00;
      operand_bit_out <= 3'd0;
    end
    else if (state_reg == ST_OPERANDS && operand_valid_in)
    begin
      first_operand_reg <= operand_in;
      case (current_reg.mode)
        MODE_WREG_WREG, MODE_WREG_IWREG:
          operand_reg_out <= {4'h0, operand_in[7:4] & WORK_REG_MAX};
        MODE_PAIR, MODE_TABLE_IND:
          operand_reg_out <= operand_in & PAIR_REG_MAX;
        MODE_IND_PAIR, MODE_SHORT_INDEX, MODE_LONG_INDEX:
          operand_reg_out <= {4'h0, operand_in[3:0] & PAIR_IDX_MAX};
        default:
          // Short form tag C in the high nibble names a working register.
          operand_reg_out <= (operand_in[7:4] == WORK_SHORT_TAG) ?
                             {4'h0, operand_in[3:0]} : operand_in;
      endcase
      // Bit-load style forms use bit 0; others take the encoded bit field.
      operand_bit_out <= (current_reg.op == OP_BIT_OR || current_reg.op == OP_BIT_XOR ||
                          current_reg.op == OP_BIT_LOAD || current_reg.op == OP_BIT_AND) ?
                         3'd0 : operand_in[3:1];
    end
  end

  // Target address forming for relative, indexed, direct and immediate forms.
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      target_out <= '0;
      target_valid_out <= 1'b0;
    end
    else
    begin
      target_valid_out <= 1'b0;
      if (state_reg == ST_OPERANDS && operand_valid_in && remaining_reg == 2'd1)
      begin
        target_valid_out <= 1'b1;
        case (current_reg.mode)
          MODE_PC_REL, MODE_BIT:
            target_out <= next_pc_in + {{8{operand_in[7]}}, operand_in};
          MODE_SHORT_INDEX:
            target_out <= {8'h00, first_operand_reg} +
                          {{8{operand_in[7]}}, operand_in};
          default:
            target_out <= {first_operand_reg, operand_in};
        endcase
      end
    end
  end

  // ==========================================================================
  // Status register
  // ==========================================================================
  // When an opcode and a status write collide the result is unpredictable; the
  // opcode's bit update wins here simply because it comes after the write.
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      status_reg <= STATUS_RESET;
    else
    begin
      if (reg_write_in && reg_addr_in == STATUS_ADDR)
        status_reg <= reg_wdata_in;
      if (flags_update_in)
        status_reg[7:2] <= flags_result_in;
      if (accept && opcode_in == OPC_SEL_BANK0)
        status_reg[BANK_BIT] <= 1'b0;
      if (accept && opcode_in == OPC_SEL_BANK1)
        status_reg[BANK_BIT] <= 1'b1;
      if (accept && opcode_in == OPC_IRQ_RETURN && status_reg[FAST_IRQ_BIT])
        status_reg[FAST_IRQ_BIT] <= 1'b0;
      if (fast_irq_begin_in)
        status_reg[FAST_IRQ_BIT] <= 1'b1;
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      reg_rdata_out <= 8'h00;
    else if (reg_read_in && reg_addr_in == STATUS_ADDR)
      reg_rdata_out <= status_reg;
    else
      reg_rdata_out <= 8'h00;
  end

  assign irq_block_out = status_reg[FAST_IRQ_BIT];
  assign bank_select_out = status_reg[BANK_BIT];

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_fast_entry;
    fast_irq_begin_in;
  endsequence

  // Leaving service with no new fast entry in the same cycle must drop the block.
  sequence s_fast_leave;
    accept && opcode_in == OPC_IRQ_RETURN && irq_block_out && !fast_irq_begin_in;
  endsequence

  a_fast_irq_set: assert property (@(posedge clock_in) disable iff (reset_in)
    s_fast_entry |=> irq_block_out) else $error("fast status not set");
  a_fast_irq_clear: assert property (@(posedge clock_in) disable iff (reset_in)
    s_fast_leave |=> !irq_block_out) else $error("fast status not cleared");
  a_irq_blocked: assert property (@(posedge clock_in) disable iff (reset_in)
    (!fast_irq_begin_in && !(accept && opcode_in == OPC_IRQ_RETURN) &&
    !(reg_write_in && reg_addr_in == STATUS_ADDR)) |=> irq_block_out == $past(irq_block_out))
    else $error("irq block changed");
  a_fast_return: assert property (@(posedge clock_in) disable iff (reset_in)
    (accept && opcode_in == OPC_IRQ_RETURN && irq_block_out) |-> decode_out.fast_return)
    else $error("fast return missed");
  a_bank_zero: assert property (@(posedge clock_in) disable iff (reset_in)
    (accept && opcode_in == OPC_SEL_BANK0 && !reg_write_in) |=> !bank_select_out)
    else $error("bank not cleared");
  a_bank_one: assert property (@(posedge clock_in) disable iff (reset_in)
    (accept && opcode_in == OPC_SEL_BANK1 && !reg_write_in) |=> bank_select_out)
    else $error("bank not set");
  a_status_read: assert property (@(posedge clock_in) disable iff (reset_in)
    (reg_read_in && reg_addr_in == STATUS_ADDR) |=> reg_rdata_out == $past(status_reg))
    else $error("status read wrong");
  a_invalid_slot: assert property (@(posedge clock_in) disable iff (reset_in)
    (accept && opcode_in == {NIB_D, NIB_5}) |-> decode_out.invalid)
    else $error("slot not invalid");
  a_same_cycle: assert property (@(posedge clock_in) disable iff (reset_in)
    accept |-> decode_out.valid) else $error("decode late");
  a_multiply_op_decode: assert property (@(posedge clock_in) disable iff (reset_in)
    (accept && opcode_in == {NIB_8, NIB_4}) |-> decode_out.op == OP_MULTIPLY)
    else $error("multiply missed");
  a_pair_even: assert property (@(posedge clock_in) disable iff (reset_in)
    (state_reg == ST_OPERANDS && operand_valid_in && current_reg.mode == MODE_PAIR)
    |=> !operand_reg_out[0]) else $error("pair odd");

endmodule

// ==== verification/fetch_model.sv ====
// Behavioural instruction fetch path that offers opcode and operand bytes.
`timescale 1ns/100ps

module fetch_model
(
  input wire logic clock_in,
  input wire logic opcode_ready_in,
  output logic opcode_valid_out,
  output logic [7:0] opcode_out,
  output logic operand_valid_out,
  output logic [7:0] operand_out
);
  // ==========================================================================
  // Fetch sequence
  // ==========================================================================
  // All lines start idle so the decoder sees no request before reset ends.
  initial
  begin
    opcode_valid_out = 1'b0;
    opcode_out = 8'hFF;
    operand_valid_out = 1'b0;
    operand_out = 8'hFF;
  end

  // Offers one opcode and then feeds bytes for as long as the decoder is not ready.
  // Released data lines show the inverse of their last value, so a stale byte never looks fresh.
  task automatic fetch(input logic [7:0] opc);
    int k;
    k = 0;
    @(posedge clock_in);
    opcode_valid_out <= 1'b1;
    opcode_out <= opc;
    @(posedge clock_in);
    while (opcode_ready_in !== 1'b1 && k < 8)
    begin
      k++;
      @(posedge clock_in);
    end
    opcode_valid_out <= 1'b0;
    opcode_out <= ~opc;
    #1;
    k = 0;
    while (opcode_ready_in !== 1'b1 && k < 4)
    begin
      operand_valid_out <= 1'b1;
      operand_out <= 8'(8'h12 + 8'h22 * k);
      k++;
      @(posedge clock_in);
      #1;
    end
    operand_valid_out <= 1'b0;
    operand_out <= ~operand_out;
  endtask
endmodule

// ==== verification/tb_top.sv ====
// Self-checking testbench for the opcode decoder and its status register.
`timescale 1ns/100ps

module tb_top;
  import opdec_pkg::*;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic ov, pv, fib = 1'b0, fup = 1'b0, wr_s = 1'b0, rd_s = 1'b0, rdy, blk, bank, tv;
  logic [7:0] opc, opd, addr = 8'h00, wdat = 8'h00, rdat;
  logic [5:0] fres = 6'h00;
  logic [15:0] tgt;
  logic [7:0] oreg;
  logic [2:0] obit;
  decode_t dec;
  int failures = 0;
  int check_count = 0;

  // ==========================================================================
  // Clock, design and partner
  // ==========================================================================
  // A 20 ns period gives the 50 MHz core clock.
  always #10 clock_in = ~clock_in;

  opcode_decoder dut (.clock_in(clock_in), .reset_in(reset_in), .opcode_valid_in(ov),
    .opcode_in(opc), .operand_valid_in(pv), .operand_in(opd), .next_pc_in(16'h0100),
    .fast_irq_begin_in(fib), .flags_update_in(fup), .flags_result_in(fres),
    .reg_addr_in(addr), .reg_wdata_in(wdat), .reg_write_in(wr_s), .reg_read_in(rd_s),
    .reg_rdata_out(rdat), .decode_out(dec), .opcode_ready_out(rdy), .irq_block_out(blk),
    .bank_select_out(bank), .operand_reg_out(oreg), .operand_bit_out(obit), .target_out(tgt),
    .target_valid_out(tv));

  fetch_model fm (.clock_in(clock_in), .opcode_ready_in(rdy), .opcode_valid_out(ov),
    .opcode_out(opc), .operand_valid_out(pv), .operand_out(opd));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic op(input logic [7:0] code, input operation_t e);
    fm.fetch(code);
    chk("operation", 16'(e), 16'(dec.op));
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    wdat <= d;
    wr_s <= 1'b1;
    @(posedge clock_in);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_in);
    rd_s <= 1'b0;
    #1;
    chk("read data", 16'(e), 16'(rdat));
  endtask

  // Raises the flag-update strobe or the fast-entry strobe for exactly one cycle.
  task automatic pulse(input bit to_flags);
    @(posedge clock_in);
    if (to_flags)
      fup <= 1'b1;
    else
      fib <= 1'b1;
    @(posedge clock_in);
    fup <= 1'b0;
    fib <= 1'b0;
    #1;
  endtask

  task automatic print_verdict;
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================================
  // Tests
  // ==========================================================================
  // Long enough for every test several times over, so only a hang reaches it.
  initial
  begin
    #100000;
    failures++;
    print_verdict;
  end

  initial
  begin
    repeat (10) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(STATUS_ADDR, STATUS_RESET);
    chk("ready", 16'h0001, 16'(rdy));
    rd(8'h00, 8'h00);
    op(8'h02, OP_ADD);
    chk("work reg", 16'h0001, 16'(oreg));
    op(8'h04, OP_ADD);
    op(8'h14, OP_ADC);
    op(8'h24, OP_SUB);
    op(8'h34, OP_SUB_BORROW);
    op(8'h44, OP_OR);
    op(8'h54, OP_AND);
    op(8'h64, OP_TEST_INV_MASK);
    op(8'h74, OP_TEST_MASK);
    op(8'hA4, OP_COMPARE);
    op(8'hB4, OP_XOR);
    op(8'h00, OP_DECREMENT);
    op(8'h10, OP_ROT_LEFT_CARRY);
    op(8'h20, OP_INC);
    op(8'h40, OP_DECIMAL_ADJUST);
    op(8'h50, OP_POP);
    op(8'h60, OP_COM);
    op(8'h90, OP_ROT_LEFT);
    op(8'hB0, OP_CLEAR);
    op(8'hC0, OP_ROT_RIGHT_CARRY);
    op(8'hD1, OP_ARITH_SHIFT_RIGHT);
    op(8'hE0, OP_ROT_RIGHT);
    op(8'hF0, OP_SWAP);
    op(8'h84, OP_MULTIPLY);
    op(8'h96, OP_DIV);
    op(8'h80, OP_WORD_DECREMENT);
    chk("pair reg", 16'h0012, 16'(oreg));
    op(8'hA1, OP_WORD_INCREMENT);
    op(8'hC6, OP_WORD_LOAD);
    op(8'h82, OP_PUSH_UD);
    op(8'h83, OP_PUSH_UI);
    op(8'h92, OP_POP_UD);
    op(8'h93, OP_POP_UI);
    op(8'h07, OP_BIT_OR);
    chk("bit field", 16'h0000, 16'(obit));
    op(8'h17, OP_BIT_CMP);
    chk("bit field", 16'h0002, 16'(obit));
    op(8'h27, OP_BIT_XOR);
    op(8'h37, OP_BIT_BRANCH);
    op(8'h47, OP_BIT_LOAD);
    op(8'h57, OP_BIT_INV);
    op(8'h67, OP_BIT_AND);
    op(8'h77, OP_BIT_SETRST);
    op(8'hC3, OP_PM_LOAD);
    op(8'hE2, OP_PM_LOAD_DEC);
    op(8'hE3, OP_PM_LOAD_INC);
    op(8'hF2, OP_PM_STORE_PD);
    op(8'hF3, OP_PM_STORE_PI);
    op(8'hA7, OP_PM_LOAD);
    op(8'h30, OP_JUMP);
    chk("pair index", 16'h0002, 16'(oreg));
    op(8'h31, OP_SET_RP);
    op(8'hD4, OP_CALL);
    op(8'hC2, OP_CMP_INC_EQ);
    op(8'hD2, OP_CMP_INC_NE);
    chk("relative target", 16'h0134, tgt);
    op(8'hE7, OP_PM_LOAD);
    chk("short index target", 16'h0046, tgt);
    op(8'hF6, OP_CALL);
    chk("target", 16'h1234, tgt);
    chk("target valid", 16'h0001, 16'(tv));
    op(8'hD5, OP_INVALID);
    chk("invalid", 16'h0001, 16'(dec.invalid));
    op(OPC_IRQ_RETURN, OP_UPPER_HALF);
    chk("fast return", 16'h0000, 16'(dec.fast_return));
    pulse(1'b0);
    chk("irq block", 16'h0001, 16'(blk));
    op(OPC_IRQ_RETURN, OP_UPPER_HALF);
    chk("fast return", 16'h0001, 16'(dec.fast_return));
    rd(STATUS_ADDR, 8'h00);
    op(OPC_SEL_BANK1, OP_UPPER_HALF);
    rd(STATUS_ADDR, 8'h01);
    op(OPC_SEL_BANK0, OP_UPPER_HALF);
    chk("bank", 16'h0000, 16'(bank));
    wr(STATUS_ADDR, 8'h03);
    rd(STATUS_ADDR, 8'h03);
    chk("irq block", 16'h0001, 16'(blk));
    fres <= 6'h2A;
    pulse(1'b1);
    rd(STATUS_ADDR, 8'hAB);
    print_verdict;
  end
endmodule
